// >>> hw/scb_map.svh
// Purpose: Offsets, field positions and reset values of the clock and busy
//   port block
// Assumes: Byte addresses on a 32-bit classic Wishbone bus
// Notes: Definitions only
`ifndef SCB_MAP_SVH
`define SCB_MAP_SVH

`define SCB_OFF_LATCH 8'h00
`define SCB_OFF_DIR 8'h04
`define SCB_OFF_PER 8'h08
`define SCB_OFF_SPS 8'h0c
`define SCB_OFF_STAT 8'h10

`define SCB_BUSY_BIT 1
`define SCB_GATE_BIT 2
`define SCB_CODE_A_LSB 0
`define SCB_CODE_B_LSB 4
`define SCB_STAT_GATE 0
`define SCB_STAT_PIN 1
`define SCB_STAT_OE 2

`define SCB_RST_LATCH 8'hff
`define SCB_RST_DIR 8'hff
`define SCB_RST_PER 8'h00
`define SCB_RST_SPS 16'h0000

`endif

// >>> hw/scb_pkg.sv
// Purpose: Types shared by the clock and busy port block
// Assumes: Widths fixed for a 4-bit divider code
// Notes: Offsets and values live in scb_map.svh
package scb_pkg;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } scb_wb_req_t;

  typedef struct packed {
    logic [7:0] latch;
    logic [7:0] dir;
    logic [7:0] per;
    logic [15:0] sps;
    logic [14:0] cnt;
    logic ack;
    logic [31:0] rdat;
    logic gate;
    logic tick_a;
    logic tick_b;
    logic pin_o;
    logic pin_oe;
  } scb_state_t;

endpackage

// >>> hw/scb_clock_busy.sv
// Purpose: Serial unit clock gate, operation clock prescaler and busy port
// Assumes: All inputs synchronous to core_clk; rst synchronous, active high
// Notes: Operation clocks are one-cycle enable ticks, not real clocks
//
// Added by the designer: the Wishbone slave port and the register offsets.
`include "scb_map.svh"

// How it works
// - Serial unit clock runs only while enabled
// - Clock A is system clock over 2^code
// - Output mode pin follows written latch value
// - Input mode latch read returns pin level
// - Direction bit 0 drives pin, 1 releases
// - Transmit data loaded clears the busy latch bit, driving the pin low in output mode only
module scb_clock_busy
  import scb_pkg::*;
#(
  parameter int CODE_W = 4
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire scb_wb_req_t wb_req,
  output logic wb_ack,
  output logic [31:0] wb_dat,
  input wire logic busy_pin_in,
  output logic busy_pin_out,
  output logic busy_pin_oe,
  input wire logic tx_loaded,
  input wire logic xfer_done,
  output logic serial_unit_clock_gate,
  output logic op_clock_a,
  output logic op_clock_b
);

  localparam scb_state_t RST_S = '{
    latch: `SCB_RST_LATCH,
    dir: `SCB_RST_DIR,
    per: `SCB_RST_PER,
    sps: `SCB_RST_SPS,
    default: '0
  };

  // Counter width and mask function are sized for a 4-bit code only
  generate
    if (CODE_W != 4) begin : g_bad_code
      $error("scb_clock_busy supports only CODE_W of 4");
    end
  endgenerate

  scb_state_t s;
  scb_state_t next_s;
  logic req;
  logic [7:0] latch_view;
  logic [3:0] clock_a_divider_code;
  logic [3:0] clock_b_divider_code;

  function automatic logic [14:0] div_mask(input logic [3:0] code);
    div_mask = 15'((16'h0001 << code) - 16'h0001);
  endfunction

  assign clock_a_divider_code = s.sps[`SCB_CODE_A_LSB +: 4];
  assign clock_b_divider_code = s.sps[`SCB_CODE_B_LSB +: 4];

  always_comb begin
    next_s = s;
    req = wb_req.cyc && wb_req.stb && !s.ack;
    latch_view = s.latch;
    if (s.dir[`SCB_BUSY_BIT]) begin
      latch_view[`SCB_BUSY_BIT] = busy_pin_in;
    end
    next_s.ack = req;
    next_s.rdat = '0;
    if (req && wb_req.we) begin
      case (wb_req.adr)
        `SCB_OFF_LATCH: begin
          if (wb_req.sel[0]) begin
            next_s.latch = wb_req.dat[7:0];
          end
        end
        `SCB_OFF_DIR: begin
          if (wb_req.sel[0]) begin
            next_s.dir = wb_req.dat[7:0];
          end
        end
        `SCB_OFF_PER: begin
          if (wb_req.sel[0]) begin
            next_s.per = wb_req.dat[7:0];
          end
        end
        `SCB_OFF_SPS: begin
          if (wb_req.sel[0]) begin
            next_s.sps[7:0] = wb_req.dat[7:0];
          end
          if (wb_req.sel[1]) begin
            next_s.sps[15:8] = wb_req.dat[15:8];
          end
        end
        default: begin
        end
      endcase
    end
    if (req && !wb_req.we) begin
      case (wb_req.adr)
        `SCB_OFF_LATCH: next_s.rdat = {24'h000000, latch_view};
        `SCB_OFF_DIR: next_s.rdat = {24'h000000, s.dir};
        `SCB_OFF_PER: next_s.rdat = {24'h000000, s.per};
        `SCB_OFF_SPS: next_s.rdat = {16'h0000, s.sps};
        `SCB_OFF_STAT: begin
          next_s.rdat[`SCB_STAT_GATE] = s.gate;
          next_s.rdat[`SCB_STAT_PIN] = busy_pin_in;
          next_s.rdat[`SCB_STAT_OE] = s.pin_oe;
        end
        default: next_s.rdat = '0;
      endcase
    end
    // Channel events beat a software write in the same cycle
    if (xfer_done) begin
      next_s.latch[`SCB_BUSY_BIT] = 1'b1;
    end
    if (tx_loaded) begin
      next_s.latch[`SCB_BUSY_BIT] = 1'b0;
    end
    next_s.gate = next_s.per[`SCB_GATE_BIT];
    // Counter parked at zero while gated so ticks restart cleanly
    next_s.cnt = next_s.gate ? 15'(s.cnt + 15'h0001) : '0;
    next_s.tick_a = next_s.gate &&
      ((next_s.cnt & div_mask(next_s.sps[`SCB_CODE_A_LSB +: 4])) == '0);
    next_s.tick_b = next_s.gate &&
      ((next_s.cnt & div_mask(next_s.sps[`SCB_CODE_B_LSB +: 4])) == '0);
    next_s.pin_o = next_s.latch[`SCB_BUSY_BIT];
    next_s.pin_oe = !next_s.dir[`SCB_BUSY_BIT];
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s <= RST_S;
    end else begin
      s <= next_s;
    end
  end

  assign wb_ack = s.ack;
  assign wb_dat = s.rdat;
  assign busy_pin_out = s.pin_o;
  assign busy_pin_oe = s.pin_oe;
  assign serial_unit_clock_gate = s.gate;
  assign op_clock_a = s.tick_a;
  assign op_clock_b = s.tick_b;

  default clocking @(posedge core_clk);
  endclocking
  default disable iff (rst);

  sequence wr_to(logic [7:0] off);
    wb_req.cyc && wb_req.stb && wb_req.we && !wb_ack &&
      wb_req.sel[0] && wb_req.adr == off;
  endsequence

  sequence quiet_events;
    !tx_loaded && !xfer_done;
  endsequence

  sequence a_div4_tick;
    op_clock_a && serial_unit_clock_gate && clock_a_divider_code == 4'h2;
  endsequence

  sequence a_div4_hold;
    (serial_unit_clock_gate && clock_a_divider_code == 4'h2) [*4];
  endsequence

  gate_enable_write_a: assert property (
    wr_to(`SCB_OFF_PER) |=>
      serial_unit_clock_gate == $past(wb_req.dat[`SCB_GATE_BIT]))
    else $error("clock gate did not follow enable write");

  gate_stops_ticks_a: assert property (
    !serial_unit_clock_gate |-> !op_clock_a && !op_clock_b)
    else $error("operation clock tick while gate is off");

  clock_a_div4_a: assert property (
    a_div4_tick ##1 a_div4_hold |->
      op_clock_a && !$past(op_clock_a) && !$past(op_clock_a, 2) &&
      !$past(op_clock_a, 3))
    else $error("clock A not one tick in four at code 2");

  clock_a_full_a: assert property (
    serial_unit_clock_gate && $past(serial_unit_clock_gate) &&
      clock_a_divider_code == 4'h0 |-> op_clock_a)
    else $error("clock A missing tick at code 0");

  clock_b_div2_a: assert property (
    op_clock_b && clock_b_divider_code == 4'h1 ##1
      (serial_unit_clock_gate && clock_b_divider_code == 4'h1) [*2] |->
      op_clock_b && !$past(op_clock_b))
    else $error("clock B not one tick in two at code 1");

  busy_write_drive_a: assert property (
    wr_to(`SCB_OFF_LATCH) and quiet_events |=>
      busy_pin_out == $past(wb_req.dat[`SCB_BUSY_BIT]))
    else $error("busy pin did not follow latch write");

  input_read_pin_a: assert property (
    wb_req.cyc && wb_req.stb && !wb_req.we && !wb_ack &&
      wb_req.adr == `SCB_OFF_LATCH && busy_pin_oe == 1'b0 |=>
      wb_ack && wb_dat[`SCB_BUSY_BIT] == $past(busy_pin_in))
    else $error("latch read in input mode did not show pin");

  dir_buffer_a: assert property (
    wr_to(`SCB_OFF_DIR) |=>
      busy_pin_oe == !$past(wb_req.dat[`SCB_BUSY_BIT]))
    else $error("output buffer did not follow direction write");

  loaded_busy_low_a: assert property (
    tx_loaded |=> !busy_pin_out)
    else $error("busy not driven low after data load");

  done_busy_high_a: assert property (
    xfer_done && !tx_loaded |=> busy_pin_out)
    else $error("busy not raised after transfer end");

  ack_single_a: assert property (
    wb_ack |=> !wb_ack)
    else $error("bus ack held longer than one cycle");

endmodule

// >>> bench/scb_busy_master.sv
// Purpose: Serial master model watching the busy pin
// Assumes: Busy pin has a pull-up at the master
// Notes: pull_low is the master pulling an undriven pin low
module scb_busy_master (
  input wire logic busy_pin_out,
  input wire logic busy_pin_oe,
  input wire logic pull_low,
  output logic busy_pin_in,
  output logic may_start
);
  timeunit 1ns;
  timeprecision 1ps;
  // Released pin floats to the pull-up level
  assign busy_pin_in = busy_pin_oe ? busy_pin_out : !pull_low;
  assign may_start = (busy_pin_in === 1'b0);
endmodule

// >>> bench/tb_scb_clock_busy.sv
// Purpose: Bench for the clock gate, prescaler and busy port
// Assumes: Classic Wishbone single cycles, ack awaited
// Notes: Ticks counted over windows that the period divides
`include "scb_map.svh"
module tb_scb_clock_busy
  import scb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  scb_wb_req_t req = '0;
  logic tx_loaded = 1'b0;
  logic xfer_done = 1'b0;
  logic pull_low = 1'b0;
  logic ack, pin_in, pin_out, oe, may_start, gate, tick_a, tick_b;
  logic [31:0] rdat, got;
  int error_cnt = 0;
  int compares = 0;
  int na = 0;
  int nb = 0;
  always #20 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    na <= na + int'(tick_a);
    nb <= nb + int'(tick_b);
  end
  scb_clock_busy i_scb_clock_busy (.core_clk(core_clk), .rst(rst),
    .wb_req(req), .wb_ack(ack), .wb_dat(rdat), .busy_pin_in(pin_in),
    .busy_pin_out(pin_out), .busy_pin_oe(oe), .tx_loaded(tx_loaded),
    .xfer_done(xfer_done), .serial_unit_clock_gate(gate),
    .op_clock_a(tick_a), .op_clock_b(tick_b));
  scb_busy_master i_scb_busy_master (.busy_pin_out(pin_out),
    .busy_pin_oe(oe), .pull_low(pull_low), .busy_pin_in(pin_in),
    .may_start(may_start));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    @(posedge core_clk);
    req <= '{1'b1, 1'b1, w, a, 4'hf, d};
    do @(posedge core_clk); while (ack !== 1'b1);
    got = rdat;
    req <= '0;
    @(negedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(got, e);
  endtask
  task automatic pulse(input logic load);
    @(posedge core_clk);
    tx_loaded <= load;
    xfer_done <= !load;
    @(posedge core_clk);
    tx_loaded <= 1'b0;
    xfer_done <= 1'b0;
    @(negedge core_clk);
  endtask
  // Both codes set at once; window must be a multiple of each period
  // With the gate off no tick may appear at all
  task automatic tk(input int ca, input int cb, input int w, input bit on);
    int a0, b0;
    wb(1'b1, `SCB_OFF_SPS, {24'h0, 4'(cb), 4'(ca)});
    a0 = na;
    b0 = nb;
    repeat (w) @(posedge core_clk);
    @(negedge core_clk);
    chk(32'(na - a0), on ? 32'(w >> ca) : 32'h0);
    chk(32'(nb - b0), on ? 32'(w >> cb) : 32'h0);
  endtask
  task automatic finish_test;
    $display("errors=%0d compares=%0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    rd(`SCB_OFF_LATCH, 32'hff);
    rd(`SCB_OFF_DIR, 32'hff);
    rd(`SCB_OFF_PER, 32'h00);
    rd(`SCB_OFF_SPS, 32'h0000);
    rd(8'h14, 32'h0);
    chk(oe, 1'b0);
    @(posedge core_clk);
    pull_low <= 1'b1;
    rd(`SCB_OFF_LATCH, 32'hfd);
    wb(1'b1, `SCB_OFF_DIR, 32'hfd);
    chk(oe, 1'b1);
    wb(1'b1, `SCB_OFF_LATCH, 32'hfd);
    chk(pin_in, 1'b0);
    wb(1'b1, `SCB_OFF_LATCH, 32'hff);
    chk(pin_out, 1'b1);
    pulse(1'b1);
    chk(pin_out, 1'b0);
    chk(may_start, 1'b1);
    pulse(1'b0);
    chk(may_start, 1'b0);
    wb(1'b1, `SCB_OFF_PER, 32'h04);
    chk(gate, 1'b1);
    for (int n = 0; n < 5; n++) begin
      tk(n, 4 - n, 32, 1'b1);
    end
    tk(15, 0, 32768, 1'b1);
    wb(1'b1, `SCB_OFF_PER, 32'h00);
    chk(gate, 1'b0);
    tk(0, 0, 32, 1'b0);
    repeat (8) @(posedge core_clk);
    @(negedge core_clk);
    // Status: gate off, pin driven high by the latch, buffer on
    rd(`SCB_OFF_STAT, 32'h6);
    finish_test();
  end
  // Longest window is 32768 cycles; margin for the rest
  initial begin
    repeat (40000) @(posedge core_clk);
    error_cnt++;
    finish_test();
  end
endmodule
